// file: hw/ibv_io_vector.sv
// I/O bus select, sync time-out and attention vectoring through the pointer table
`timescale 1ns/10ps
module ibv_io_vector import ibv_pkg::*; #(
  parameter int SYNC_WAIT = SYNC_WAIT_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [9:0] IO_ADDR,
  output logic IO_ADDR_VALID,
  input wire logic IO_SYNC,
  input wire logic IO_ATTN,
  output logic ACK_CHAIN_OUT,
  input wire logic [9:0] IO_DEVNUM,
  input wire logic [7:0] IO_DEVSTS,
  output logic [7:0] IO_DATA,
  output logic IO_DATA_STB,
  input wire logic EXEC_END,
  output logic SEQ_PAUSE,
  output logic MEM_REQ,
  output logic [23:0] MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA,
  output logic AUTO_STB,
  output logic [9:0] AUTO_DEV
);
  localparam logic [31:0] SYNC_LAST = 32'(SYNC_WAIT - 1);

  ibv_core_type q;
  ibv_core_type d;
  ibv_wr_type wr;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic wr_hit;
  logic prob;
  logic take_attn;
  logic sync_lost;
  logic vec_done;

  ibv_axil u_axil (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .wr(wr),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  assign IO_ADDR = q.dev;
  assign IO_ADDR_VALID = q.addr_drv;
  assign ACK_CHAIN_OUT = q.ack;
  assign SEQ_PAUSE = q.pause;
  assign IO_DATA = q.data_out;
  assign IO_DATA_STB = q.data_stb;
  assign MEM_REQ = q.mem_req;
  assign MEM_ADDR = q.mem_addr;
  assign AUTO_STB = q.auto_stb;
  assign AUTO_DEV = q.auto_dev;

  assign prob = q.program_status_word[PSW_PROB_BIT];
  assign wr_hit = (wr.addr <= OFF_DATA);
  // Attention is taken only between instructions and only while no select is open
  assign take_attn = (q.st == ST_IDLE) && IO_ATTN && EXEC_END && q.program_status_word[PSW_IE_BIT];
  assign sync_lost = !IO_SYNC && (q.cnt == SYNC_LAST);
  assign vec_done = (q.st == ST_FETCH) && MEM_ACK;

  always_comb begin
    rd_hit = 1'b1;
    case ({rd_addr[7:2], 2'b00})
      OFF_CMD: rd_data = {q.st != ST_IDLE, 21'h000000, q.dev};
      OFF_PSW: rd_data = q.program_status_word;
      OFF_LOC: rd_data = q.location_counter;
      OFF_STAT: rd_data = {13'h0000, q.pause, q.st == ST_READY, q.addr_drv, q.sts, 5'h00,
                           q.bad_dev, q.priv_err, q.fsync};
      OFF_SAVE0: rd_data = q.save[0];
      OFF_SAVE1: rd_data = q.save[1];
      OFF_SAVE2: rd_data = q.save[2];
      OFF_SAVE3: rd_data = q.save[3];
      OFF_CFG: rd_data = {30'h00000000, q.cfg};
      OFF_DATA: rd_data = {24'h000000, q.data_out};
      default: begin
        rd_data = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    d = q;
    d.data_stb = 1'b0;
    d.auto_stb = 1'b0;
    // Software effects first so that a hardware event in the same cycle wins
    if (wr.en) begin
      case (wr.addr)
        OFF_PSW: d.program_status_word = merge(q.program_status_word, wr.data, wr.strb);
        OFF_LOC: d.location_counter = merge(q.location_counter, wr.data, wr.strb);
        OFF_CFG: d.cfg = wr.strb[0] ? wr.data[1:0] : q.cfg;
        OFF_STAT: begin
          d.fsync = q.fsync & ~wr.data[STS_FSYNC_BIT];
          d.priv_err = q.priv_err & ~wr.data[STS_PRIV_BIT];
          d.bad_dev = q.bad_dev & ~wr.data[STS_BAD_BIT];
        end
        default: d.st = q.st;
      endcase
    end
    case (q.st)
      ST_IDLE: begin
        if (take_attn) begin
          d.st = ST_ACK;
          d.ack = 1'b1;
          d.pause = 1'b1;
          d.cnt = 32'h00000000;
        end
      end
      ST_SEL: begin
        d.cnt = q.cnt + 32'h00000001;
        if (IO_SYNC) begin
          d.st = ST_READY;
        end else if (sync_lost) begin
          d.st = ST_IDLE;
          d.addr_drv = 1'b0;
          d.fsync = 1'b1;
          d.sts = FALSE_SYNC_STS;
          d.program_status_word[3:0] = CC_FALSE_SYNC;
        end
      end
      ST_READY: begin
        d.cnt = 32'h00000000;
      end
      ST_ACK: begin
        d.cnt = q.cnt + 32'h00000001;
        if (IO_SYNC) begin
          d.ack = 1'b0;
          d.devnum = IO_DEVNUM;
          d.devsts = IO_DEVSTS;
          if (dev_ok(IO_DEVNUM, q.cfg)) begin
            d.st = ST_FETCH;
            d.mem_req = 1'b1;
            d.mem_addr = entry_addr(IO_DEVNUM);
          end else begin
            d.st = ST_IDLE;
            d.bad_dev = 1'b1;
            d.pause = 1'b0;
          end
        end else if (sync_lost) begin
          d.st = ST_IDLE;
          d.ack = 1'b0;
          d.pause = 1'b0;
          d.fsync = 1'b1;
          d.sts = FALSE_SYNC_STS;
          d.program_status_word[3:0] = CC_FALSE_SYNC;
        end
      end
      ST_FETCH: begin
        if (MEM_ACK) begin
          d.st = ST_IDLE;
          d.mem_req = 1'b0;
          d.pause = 1'b0;
          if (MEM_RDATA[ENTRY_AUTO_BIT]) begin
            d.auto_stb = 1'b1;
            d.auto_dev = q.devnum;
          end else begin
            d.save[0] = q.program_status_word;
            d.save[1] = q.location_counter;
            d.save[2] = {22'h000000, q.devnum};
            d.save[3] = {24'h000000, q.devsts};
            d.program_status_word = {NEW_PSW_HI, q.devsts[3:0]};
            d.location_counter = {16'h0000, MEM_RDATA};
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase
    // Commands need supervisor state; a refused one only raises a flag
    if (wr.en && (wr.addr == OFF_CMD || wr.addr == OFF_DATA) && prob) begin
      d.priv_err = 1'b1;
    end else if (wr.en && wr.addr == OFF_CMD) begin
      if (wr.data[CMD_GO_BIT] && q.st == ST_IDLE && d.st == ST_IDLE) begin
        if (dev_ok(wr.data[9:0], q.cfg)) begin
          d.st = ST_SEL;
          d.dev = wr.data[9:0];
          d.addr_drv = 1'b1;
          d.cnt = 32'h00000000;
        end else begin
          d.bad_dev = 1'b1;
        end
      end else if (wr.data[CMD_REL_BIT] && q.st == ST_READY) begin
        d.st = ST_IDLE;
        d.addr_drv = 1'b0;
      end
    end else if (wr.en && wr.addr == OFF_DATA && q.st == ST_READY) begin
      d.data_out = wr.data[7:0];
      d.data_stb = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
      q.cfg <= CFG_RST;
    end else begin
      q <= d;
    end
  end

  dev_nonzero_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    IO_ADDR_VALID |-> (IO_ADDR != 10'h000)) else $error("zero device addressed");
  sel_sync_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (q.st == ST_SEL) && IO_SYNC |=> (q.st == ST_READY) && IO_ADDR_VALID)
    else $error("sync did not complete select");
  false_sync_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (q.st == ST_SEL) && sync_lost |=> q.fsync && (q.sts == 8'h04) && (q.program_status_word[3:0] == 4'h4))
    else $error("false sync not reported");
  addr_release_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (q.st == ST_SEL) && sync_lost |=> !IO_ADDR_VALID && !IO_DATA_STB)
    else $error("address held after time-out");
  ack_enable_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(ACK_CHAIN_OUT) |-> $past(q.program_status_word[PSW_IE_BIT]) && $past(EXEC_END) && SEQ_PAUSE)
    else $error("acknowledge without permission");
  table_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(MEM_REQ) |-> (MEM_ADDR == TABLE_BASE + {13'h0000, q.devnum, 1'b0})
      && (MEM_ADDR < TABLE_END_MAX)) else $error("bad table entry address");
  new_status_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    vec_done && !MEM_RDATA[0] |=> (q.program_status_word == {28'h0000280, q.devsts[3:0]})
      && (q.location_counter == {16'h0000, $past(MEM_RDATA)}) && !q.program_status_word[PSW_IE_BIT])
    else $error("new status or location wrong");
  save_regs_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    vec_done && !MEM_RDATA[0] |=> (q.save[0] == $past(q.program_status_word)) && (q.save[1] == $past(q.location_counter))
      && (q.save[2] == {22'h000000, q.devnum})) else $error("state not saved");
  auto_path_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    vec_done && MEM_RDATA[0] |=> AUTO_STB && (AUTO_DEV == q.devnum) ##1 !AUTO_STB)
    else $error("auto channel not started");
  priv_cmd_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr.en && (wr.addr == OFF_CMD) && prob && (q.st == ST_IDLE) && !take_attn
      |=> !IO_ADDR_VALID && q.priv_err) else $error("command in problem state");
endmodule

// file: hw/ibv_pkg.sv
// Shared constants, register map and types for the I/O bus vectoring block
package ibv_pkg;
  localparam int CLK_KHZ = 125000;
  localparam int SYNC_WAIT_MS = 50;
  localparam int SYNC_WAIT_CYC = SYNC_WAIT_MS * CLK_KHZ;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_PSW = 8'h04;
  localparam logic [7:0] OFF_LOC = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_SAVE0 = 8'h10;
  localparam logic [7:0] OFF_SAVE1 = 8'h14;
  localparam logic [7:0] OFF_SAVE2 = 8'h18;
  localparam logic [7:0] OFF_SAVE3 = 8'h1c;
  localparam logic [7:0] OFF_CFG = 8'h20;
  localparam logic [7:0] OFF_DATA = 8'h24;
  localparam int CMD_GO_BIT = 31;
  localparam int CMD_REL_BIT = 30;
  localparam int STS_FSYNC_BIT = 0;
  localparam int STS_PRIV_BIT = 1;
  localparam int STS_BAD_BIT = 2;
  localparam int PSW_IE_BIT = 14;
  localparam int PSW_PROB_BIT = 8;
  localparam int ENTRY_AUTO_BIT = 0;
  localparam logic [9:0] DEV_MIN = 10'h001;
  localparam logic [9:0] DEV_MAX = 10'h3ff;
  localparam logic [9:0] DEV_SELECTOR_CHANNEL = 10'h0f0;
  localparam logic [9:0] DEV_LIM_MIN = 10'h0ff;
  localparam logic [9:0] DEV_LIM_MID = 10'h1ff;
  localparam logic [23:0] TABLE_BASE = 24'h0000d0;
  localparam logic [23:0] TABLE_END_MIN = 24'h0002cf;
  localparam logic [23:0] TABLE_END_MAX = 24'h0008cf;
  localparam logic [7:0] FALSE_SYNC_STS = 8'h04;
  localparam logic [3:0] CC_FALSE_SYNC = 4'h4;
  localparam logic [27:0] NEW_PSW_HI = 28'h0000280;
  localparam logic [1:0] CFG_RST = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_READY, ST_ACK, ST_FETCH} ibv_state_type;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } ibv_wr_type;

  typedef struct packed {
    logic aw_ok;
    logic [7:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ibv_axil_type;

  typedef struct packed {
    ibv_state_type st;
    logic [31:0] cnt;
    logic [9:0] dev;
    logic addr_drv;
    logic ack;
    logic pause;
    logic [31:0] program_status_word;
    logic [31:0] location_counter;
    logic [3:0][31:0] save;
    logic [1:0] cfg;
    logic [7:0] sts;
    logic fsync;
    logic priv_err;
    logic bad_dev;
    logic [9:0] devnum;
    logic [7:0] devsts;
    logic mem_req;
    logic [23:0] mem_addr;
    logic auto_stb;
    logic [9:0] auto_dev;
    logic [7:0] data_out;
    logic data_stb;
  } ibv_core_type;

  function automatic logic [9:0] dev_limit(input logic [1:0] cfg);
    case (cfg)
      2'h0: dev_limit = DEV_LIM_MIN;
      2'h1: dev_limit = DEV_LIM_MID;
      default: dev_limit = DEV_MAX;
    endcase
  endfunction

  function automatic logic dev_ok(input logic [9:0] dev, input logic [1:0] cfg);
    dev_ok = (dev >= DEV_MIN) && (dev <= dev_limit(cfg));
  endfunction

  function automatic logic [23:0] entry_addr(input logic [9:0] dev);
    entry_addr = TABLE_BASE + {13'h0000, dev, 1'b0};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction
endpackage

// file: hw/ibv_axil.sv
// AXI4-Lite slave front end for the vectoring block registers
`timescale 1ns/10ps
module ibv_axil import ibv_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output ibv_wr_type wr,
  input wire logic wr_hit,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);
  ibv_axil_type q;
  ibv_axil_type d;

  // One write in flight; address and data may arrive in either order
  assign awready = !q.aw_ok && !q.bvalid;
  assign wready = !q.w_ok && !q.bvalid;
  assign arready = !q.rvalid;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign rd_addr = araddr;
  assign wr.en = q.aw_ok && q.w_ok && !q.bvalid;
  assign wr.addr = {q.awaddr[7:2], 2'b00};
  assign wr.data = q.wdata;
  assign wr.strb = q.wstrb;

  always_comb begin
    d = q;
    if (awvalid && awready) begin
      d.aw_ok = 1'b1;
      d.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      d.w_ok = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    if (wr.en) begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd_hit ? rd_data : 32'h00000000;
      d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// file: verification/ibv_ctrl_model.sv
// Device controllers and pointer table memory on the far side of the I/O bus
`timescale 1ns/10ps
module ibv_ctrl_model (
  input wire logic clk,
  input wire logic [9:0] io_addr,
  input wire logic io_addr_valid,
  input wire logic ack_in,
  input wire logic [1:0] attn_set,
  input wire logic [1:0][9:0] attn_dev,
  input wire logic [7:0] attn_sts,
  input wire logic [9:0] sel_dev,
  input wire logic [3:0] lag,
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  output logic io_sync,
  output logic io_attn,
  output logic [9:0] io_devnum,
  output logic [7:0] io_devsts,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] table_mem [0:1023];
  logic [1:0] pend = 2'h0;
  logic selected = 1'b0;
  logic w;
  int sc = 0;
  int mc = 0;
  initial begin
    io_sync = 1'b0;
    io_devnum = 10'h2aa;
    io_devsts = 8'h55;
    mem_ack = 1'b0;
    mem_rdata = 16'h5a5a;
  end
  assign io_attn = |pend;
  // Index 0 sits nearest the processor and captures the acknowledge first
  assign w = !pend[0];
  always @(posedge clk) begin
    io_sync <= 1'b0;
    // Released lines toggle so a stale number never looks valid
    io_devnum <= ~io_devnum;
    io_devsts <= ~io_devsts;
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    pend <= pend | attn_set;
    selected <= selected && io_addr_valid;
    if (io_addr_valid && io_addr == sel_dev && !selected) begin
      sc <= sc + 1;
      if (sc >= lag) begin
        io_sync <= 1'b1;
        selected <= 1'b1;
        sc <= 0;
      end
    // A lag of 15 stands for a controller that never answers the acknowledge
    end else if (ack_in && |pend && !io_sync && lag != 4'hf) begin
      sc <= sc + 1;
      if (sc >= lag) begin
        io_sync <= 1'b1;
        io_devnum <= attn_dev[w];
        io_devsts <= attn_sts;
        pend[w] <= 1'b0;
        sc <= 0;
      end
    end else begin
      sc <= 0;
    end
    if (mem_req && !mem_ack) begin
      mc <= mc + 1;
      if (mc >= lag) begin
        mem_ack <= 1'b1;
        mem_rdata <= table_mem[10'((mem_addr - 24'h0000d0) >> 1)];
        mc <= 0;
      end
    end else begin
      mc <= 0;
    end
  end
endmodule

// file: verification/tb_top.sv
// Self-checking testbench for the I/O bus vectoring block
`timescale 1ns/10ps
module tb_top import ibv_pkg::*; ;
  localparam int SW = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic exec_end = 1'b0;
  logic [1:0] attn_set = 2'h0;
  logic [1:0][9:0] attn_dev = '0;
  logic [7:0] attn_sts = 8'h00;
  logic [9:0] sel_dev = 10'h000;
  logic [3:0] lag = 4'h3;
  logic awready, wready, bvalid, arready, rvalid, io_sync, io_attn, addr_vld;
  logic ack, pause, mem_req, mem_ack, data_stb, auto_stb;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata, rv;
  logic [9:0] io_addr, io_devnum, auto_dev;
  logic [7:0] io_devsts, io_data, stb_val;
  logic [23:0] mem_addr;
  logic [15:0] mem_rdata;
  logic [9:0] auto_q[$];
  int err_total = 0;
  int check_count = 0;
  int stb_cnt = 0;
  int n;

  ibv_io_vector #(.SYNC_WAIT(SW)) i_dut (
    .CLK_SYS(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IO_ADDR(io_addr), .IO_ADDR_VALID(addr_vld), .IO_SYNC(io_sync), .IO_ATTN(io_attn),
    .ACK_CHAIN_OUT(ack), .IO_DEVNUM(io_devnum), .IO_DEVSTS(io_devsts), .IO_DATA(io_data),
    .IO_DATA_STB(data_stb), .EXEC_END(exec_end), .SEQ_PAUSE(pause), .MEM_REQ(mem_req),
    .MEM_ADDR(mem_addr), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .AUTO_STB(auto_stb),
    .AUTO_DEV(auto_dev));

  ibv_ctrl_model i_ctrl (.clk(clk), .io_addr(io_addr), .io_addr_valid(addr_vld), .ack_in(ack),
    .attn_set(attn_set), .attn_dev(attn_dev), .attn_sts(attn_sts), .sel_dev(sel_dev),
    .lag(lag), .mem_req(mem_req), .mem_addr(mem_addr), .io_sync(io_sync), .io_attn(io_attn),
    .io_devnum(io_devnum), .io_devsts(io_devsts), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    if (data_stb === 1'b1) begin
      stb_cnt++;
      stb_val = io_data;
    end
    if (auto_stb === 1'b1) begin
      auto_q.push_back(auto_dev);
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!ad || !wd) begin
      @(posedge clk);
      if (awready && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Ready stays high between transfers so no line is set twice in one step
    do @(posedge clk); while (bvalid !== 1'b1);
    chk("bresp", bresp, er);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rv = rdata;
    rr = rresp;
  endtask

  task automatic t_reset;
    chk("idle_outs", {addr_vld, ack, pause, mem_req, auto_stb}, 0);
    rd(OFF_CFG);
    chk("cfg_rst", rv, 32'h2);
    rd(OFF_PSW);
    chk("psw_rst", rv, 32'h0);
    rd(8'h40);
    chk("rd_unmapped", {rr, rv}, {RESP_SLVERR, 32'h0});
    wr(8'h40, 32'h1, RESP_SLVERR);
  endtask

  task automatic t_select;
    sel_dev <= DEV_MAX;
    wr(OFF_CMD, {22'h200000, DEV_MAX}, RESP_OKAY);
    for (n = 0; n < 8 && addr_vld !== 1'b1; n++) @(posedge clk);
    chk("sel_addr", {addr_vld, io_addr}, {1'b1, DEV_MAX});
    repeat (8) @(posedge clk);
    rd(OFF_STAT);
    chk("ready", rv[17], 1'b1);
    wr(OFF_DATA, 32'h5a, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("data_stb", {stb_cnt[7:0], stb_val}, 16'h015a);
    wr(OFF_CMD, 32'h40000000, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("released", addr_vld, 1'b0);
  endtask

  task automatic t_fsync;
    sel_dev <= 10'h001;
    wr(OFF_CMD, 32'h80000002, RESP_OKAY);
    for (n = 0; n < 8 && addr_vld !== 1'b1; n++) @(posedge clk);
    for (n = 0; n < 100 && addr_vld === 1'b1; n++) @(posedge clk);
    chk("sync_wait", n, SW);
    rd(OFF_STAT);
    chk("fsync_sts", {rv[15:8], rv[0]}, {FALSE_SYNC_STS, 1'b1});
    rd(OFF_PSW);
    chk("fsync_cc", rv[3:0], CC_FALSE_SYNC);
    wr(OFF_DATA, 32'h33, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("no_cmd", {stb_cnt[7:0], addr_vld}, 9'h002);
  endtask

  task automatic t_priv;
    wr(OFF_PSW, 32'h100, RESP_OKAY);
    wr(OFF_CMD, 32'h80000001, RESP_OKAY);
    repeat (4) @(posedge clk);
    rd(OFF_STAT);
    chk("priv", {addr_vld, rv[1]}, 2'b01);
    wr(OFF_PSW, 32'h0, RESP_OKAY);
  endtask

  task automatic t_baddev;
    logic [9:0] bad [3];
    bad = '{10'h100, 10'h200, 10'h000};
    for (int c = 0; c < 3; c++) begin
      wr(OFF_CFG, c, RESP_OKAY);
      wr(OFF_CMD, {22'h200000, bad[c]}, RESP_OKAY);
      repeat (3) @(posedge clk);
      rd(OFF_STAT);
      chk("bad_dev", {addr_vld, rv[2]}, 2'b01);
      wr(OFF_STAT, 32'h7, RESP_OKAY);
    end
  endtask

  task automatic t_vec_imm;
    logic [31:0] ex [4];
    ex = '{32'h4000, 32'h1234, 32'h3ff, 32'h37};
    i_ctrl.table_mem[DEV_MAX] = 16'h3000;
    wr(OFF_LOC, 32'h1234, RESP_OKAY);
    attn_dev <= {10'h000, DEV_MAX};
    attn_sts <= 8'h37;
    exec_end <= 1'b1;
    attn_set <= 2'b01;
    @(posedge clk);
    attn_set <= 2'b00;
    repeat (6) @(posedge clk);
    chk("ack_masked", ack, 1'b0);
    exec_end <= 1'b0;
    wr(OFF_PSW, 32'h4000, RESP_OKAY);
    repeat (6) @(posedge clk);
    chk("ack_no_end", ack, 1'b0);
    exec_end <= 1'b1;
    for (n = 0; n < 20 && mem_req !== 1'b1; n++) @(posedge clk);
    chk("tbl_addr", {pause, mem_addr}, {1'b1, TABLE_END_MAX - 24'h1});
    for (n = 0; n < 20 && pause === 1'b1; n++) @(posedge clk);
    rd(OFF_PSW);
    chk("new_psw", rv, {NEW_PSW_HI, 4'h7});
    rd(OFF_LOC);
    chk("new_loc", rv, 32'h3000);
    for (int i = 0; i < 4; i++) begin
      rd(OFF_SAVE0 + 8'(4 * i));
      chk("save", rv, ex[i]);
    end
    chk("no_auto", auto_q.size(), 0);
  endtask

  task automatic t_vec_auto;
    i_ctrl.table_mem[10'h010] = 16'h4001;
    i_ctrl.table_mem[10'h0ff] = 16'h0201;
    lag <= 4'h1;
    wr(OFF_CFG, 32'h0, RESP_OKAY);
    wr(OFF_PSW, 32'h4000, RESP_OKAY);
    attn_dev <= {10'h010, 10'h0ff};
    attn_set <= 2'b11;
    @(posedge clk);
    attn_set <= 2'b00;
    for (n = 0; n < 20 && mem_req !== 1'b1; n++) @(posedge clk);
    chk("tbl_min", mem_addr, TABLE_END_MIN - 24'h1);
    repeat (40) @(posedge clk);
    chk("auto_cnt", auto_q.size(), 2);
    chk("auto_order", {auto_q[0], auto_q[1]}, {10'h0ff, 10'h010});
    rd(OFF_PSW);
    chk("psw_kept", rv, 32'h4000);
  endtask

  task automatic t_ack_lost;
    lag <= 4'hf;
    attn_set <= 2'b01;
    @(posedge clk);
    attn_set <= 2'b00;
    for (n = 0; n < 8 && ack !== 1'b1; n++) @(posedge clk);
    for (n = 0; n < 100 && ack === 1'b1; n++) @(posedge clk);
    chk("ack_wait", n, SW);
    exec_end <= 1'b0;
    rd(OFF_STAT);
    chk("ack_fsync", {rv[15:8], rv[0]}, {FALSE_SYNC_STS, 1'b1});
    rd(OFF_PSW);
    chk("ack_cc", rv[3:0], CC_FALSE_SYNC);
  endtask

  task final_report;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_select();
    t_fsync();
    t_priv();
    t_baddev();
    t_vec_imm();
    t_vec_auto();
    t_ack_lost();
    final_report();
  end
endmodule
